// ### design/sysinit_cfg.sv
// Startup configuration latches, protected mapping registers and memory-map decode.
//
// Local design decision: register access over APB.
`include "sysinit_defs.svh"
`default_nettype none
module sysinit_cfg #(
	parameter bit          HAS_SECURITY  = 1'b1,
	parameter bit          HAS_EE_PAGE   = 1'b0,
	parameter logic [15:0] RAM_BYTES     = 16'h0200,
	parameter logic [3:0]  ROM_PAGE      = 4'hD,
	parameter logic [15:0] EE_BASE       = 16'hB600,
	parameter logic [15:0] EE_BYTES      = 16'h0200
) (
	input  wire logic                ref_clk,
	input  wire logic                arst_n,
	input  wire logic                sys_reset_req,
	input  wire logic                mode_b_pin,
	input  wire logic                mode_a_pin,
	input  wire logic [7:0]          nv_config_cell,
	output logic                     nv_prog_strobe,
	output logic [7:0]               nv_prog_data,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [15:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	input  wire logic                cpu_req,
	input  wire logic [15:0]         cpu_addr,
	output sysinit_pkg::map_sel_s    map_sel,
	output sysinit_pkg::config_s     config_latch,
	output sysinit_pkg::option_s     option_bits,
	output logic [3:0]               ram_page,
	output logic [3:0]               reg_page,
	output logic                     special_mode,
	output logic                     security_enabled,
	output logic                     watchdog_disable
);
	import sysinit_pkg::*;

	localparam logic [15:0] ADDR_OPTION  = 16'(`IDX_OPTION * 4);
	localparam logic [15:0] ADDR_MAP_POS = 16'(`IDX_MAP_POSITION * 4);
	localparam logic [15:0] ADDR_TEST    = 16'(`IDX_TEST_CTRL * 4);
	localparam logic [15:0] ADDR_CONFIG  = 16'(`IDX_CONFIG * 4);
	localparam logic [15:0] ADDR_STATUS  = 16'(`IDX_STATUS * 4);

	// All state of the block.
	typedef struct packed {
		seq_state_e  seq;
		logic [2:0]  mode_b_sync;
		logic [2:0]  mode_a_sync;
		logic        mode_b_filt;
		logic        mode_a_filt;
		logic        special_mode_flag;
		logic        mda;
		config_s     cfg;
		option_s     opt;
		logic [3:0]  ram_pg;
		logic [3:0]  reg_pg;
		logic        test_wdog_block;
		logic [6:0]  window_cnt;
		logic [2:0]  settle_cnt;
		logic        map_written;
		logic        opt_written;
		logic        nv_strobe;
		logic [7:0]  nv_data;
		logic        ready;
		logic [31:0] rdata;
		logic        slverr;
		map_sel_s    sel;
		logic        sec_en;
		logic        wdog_dis;
	} state_s;

	state_s state_q;
	state_s state_d;

	logic       access;
	logic       commit;
	logic       window_open;
	logic       map_wr_ok;
	logic       opt_wr_ok;
	logic       mapped;
	logic [7:0] cfg_read;
	logic [7:0] rd_byte;
	logic       rom_on;
	logic [15:0] ee_lo;
	logic [15:0] ee_hi;

	// Read view of the latches; unbuilt options show their fixed values.
	always_comb
	begin
		cfg_read = state_q.cfg;
		if (!HAS_EE_PAGE)
		begin
			cfg_read[`CFG_EE_PAGE_HI:`CFG_EE_PAGE_LO] = 4'h0;
		end
		if (!HAS_SECURITY)
		begin
			cfg_read[`CFG_SEC_OFF] = 1'b1; // [R4]
		end
	end

	// Write qualifiers for the protected registers.
	always_comb
	begin
		access      = psel && penable;
		commit      = access && state_q.ready && state_q.seq == ST_RUN;
		window_open = state_q.window_cnt < `WINDOW_CYCLES;
		map_wr_ok   = state_q.special_mode_flag || (window_open && !state_q.map_written); // [R11] [R16]
		opt_wr_ok   = state_q.special_mode_flag || (window_open && !state_q.opt_written); // [R14] [R15]
	end

	// Register read mux and decode of the bus address.
	always_comb
	begin
		mapped  = 1'b1;
		rd_byte = 8'h00;
		if (paddr == ADDR_OPTION)
		begin
			rd_byte = state_q.opt;
		end
		else if (paddr == ADDR_MAP_POS)
		begin
			rd_byte = {state_q.ram_pg, state_q.reg_pg};
		end
		else if (paddr == ADDR_TEST)
		begin
			rd_byte = {7'h00, state_q.test_wdog_block};
		end
		else if (paddr == ADDR_CONFIG)
		begin
			rd_byte = cfg_read; // [R3]
		end
		else if (paddr == ADDR_STATUS)
		begin
			rd_byte = {3'h0, state_q.opt_written, state_q.map_written,
				window_open, state_q.special_mode_flag, state_q.mda};
		end
		else
		begin
			mapped = 1'b0;
		end
	end

	// Effective memory-map controls used by the decoder.
	always_comb
	begin
		rom_on = state_q.cfg.rom_map_enable || (!state_q.special_mode_flag && !state_q.mda); // [R7]
		if (HAS_EE_PAGE)
		begin
			ee_lo = {state_q.cfg.eeprom_page_select, `EE_PAGE_OFFSET}; // [R9]
			ee_hi = {state_q.cfg.eeprom_page_select, 12'hFFF}; // [R9]
		end
		else
		begin
			ee_lo = EE_BASE;
			ee_hi = 16'(EE_BASE + EE_BYTES - 16'h0001);
		end
	end

	// Next-state logic for the whole block.
	always_comb
	begin
		state_d = state_q;

		// Mode pins: three flops, a change counts once the last two agree.
		state_d.mode_b_sync = {state_q.mode_b_sync[1:0], mode_b_pin};
		state_d.mode_a_sync = {state_q.mode_a_sync[1:0], mode_a_pin};
		if (state_q.mode_b_sync[1] == state_q.mode_b_sync[2])
		begin
			state_d.mode_b_filt = state_q.mode_b_sync[2];
		end
		if (state_q.mode_a_sync[1] == state_q.mode_a_sync[2])
		begin
			state_d.mode_a_filt = state_q.mode_a_sync[2];
		end

		state_d.nv_strobe = 1'b0;

		case (state_q.seq)
			ST_LOAD:
			begin
				// The hard reset loads fixed values into the filter flops, so the first load waits
				// until they hold the pins; later loads find the counter saturated.
				if (state_q.settle_cnt < `SETTLE_CYCLES)
				begin
					state_d.settle_cnt = 3'(state_q.settle_cnt + 3'd1);
				end
				else
				begin
					// The reset sequence latches mode and configuration in one cycle.
					state_d.special_mode_flag = !state_q.mode_b_filt;
					state_d.mda  = state_q.mode_a_filt;
					state_d.cfg  = nv_config_cell; // [R1] [R2]
					if (!state_q.mode_b_filt)
					begin
						state_d.cfg.watchdog_off = state_q.cfg.watchdog_off; // [R10]
					end
					state_d.opt             = `RST_OPTION;
					state_d.ram_pg          = `RST_RAM_PAGE; // [R12]
					state_d.reg_pg          = `RST_REG_PAGE; // [R13]
					state_d.test_wdog_block = 1'b0;
					state_d.window_cnt      = 7'd0;
					state_d.map_written     = 1'b0;
					state_d.opt_written     = 1'b0;
					state_d.seq             = ST_RUN;
				end
			end
			ST_RUN:
			begin
				// The window counter saturates so it stays closed until the next reset sequence.
				if (window_open)
				begin
					state_d.window_cnt = 7'(state_q.window_cnt + 7'd1);
				end
				if (sys_reset_req)
				begin
					state_d.seq = ST_LOAD;
				end
			end
			default:
			begin
				state_d.seq = ST_LOAD;
			end
		endcase

		// APB slave: one wait state, answer registered at the first access edge.
		if (access && !state_q.ready)
		begin
			state_d.ready  = 1'b1;
			state_d.slverr = !mapped;
			state_d.rdata  = {24'h00_0000, rd_byte};
		end
		else
		begin
			state_d.ready  = 1'b0;
			state_d.slverr = 1'b0;
		end

		// Writes take effect at the edge where pready is sampled high.
		if (commit && pwrite && mapped)
		begin
			if (paddr == ADDR_OPTION)
			begin
				state_d.opt.adc_power_up         = pwdata[7];
				state_d.opt.alt_clock_select     = pwdata[6];
				state_d.opt.clock_monitor_enable = pwdata[3];
				if (opt_wr_ok)
				begin
					state_d.opt.irq_edge_only   = pwdata[5]; // [R14]
					state_d.opt.stop_wake_delay = pwdata[4]; // [R14]
					state_d.opt.watchdog_rate   = pwdata[1:0]; // [R14]
					state_d.opt_written         = 1'b1; // [R14]
				end
			end
			else if (paddr == ADDR_MAP_POS)
			begin
				if (map_wr_ok)
				begin
					state_d.ram_pg      = pwdata[7:4]; // [R12] [R17]
					state_d.reg_pg      = pwdata[3:0]; // [R13] [R17]
					state_d.map_written = 1'b1; // [R11]
				end
			end
			else if (paddr == ADDR_TEST)
			begin
				if (state_q.special_mode_flag)
				begin
					state_d.test_wdog_block = pwdata[0]; // [R16]
				end
			end
			else if (paddr == ADDR_CONFIG)
			begin
				// The write goes to the cell only; latches wait for a reset sequence.
				state_d.nv_strobe = 1'b1; // [R3] [R2]
				state_d.nv_data   = pwdata[7:0]; // [R3]
			end
		end

		// Derived controls, registered so every output comes from a flop.
		state_d.sec_en   = HAS_SECURITY && !state_d.cfg.security_off; // [R4]
		if (state_d.special_mode_flag)
		begin
			state_d.wdog_dis = state_d.test_wdog_block; // [R10]
		end
		else
		begin
			state_d.wdog_dis = state_d.cfg.watchdog_off; // [R5]
		end

		// Memory-map decode; the register block wins over RAM, RAM over EEPROM and ROM.
		state_d.sel = '0;
		if (cpu_req)
		begin
			if (cpu_addr[15:12] == state_q.reg_pg
				&& cpu_addr[11:0] < `REG_BLOCK_BYTES) // [R13] [R17]
			begin
				state_d.sel.regs = 1'b1;
			end
			else if (cpu_addr[15:12] == state_q.ram_pg
				&& {4'h0, cpu_addr[11:0]} < RAM_BYTES) // [R12] [R17]
			begin
				state_d.sel.ram = 1'b1;
			end
			else if (state_q.cfg.eeprom_map_enable
				&& cpu_addr >= ee_lo && cpu_addr <= ee_hi) // [R8] [R9]
			begin
				state_d.sel.eeprom = 1'b1;
			end
			else if (rom_on && cpu_addr[15:12] >= ROM_PAGE) // [R6] [R7]
			begin
				state_d.sel.rom = 1'b1;
			end
			else
			begin
				state_d.sel.external = 1'b1; // [R6] [R8]
			end
		end
	end

	// One register bank for the whole state; async reset loads constants only.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q             <= '0;
			state_q.seq         <= ST_LOAD;
			state_q.cfg         <= `RST_CONFIG;
			state_q.opt         <= `RST_OPTION;
			state_q.ram_pg      <= `RST_RAM_PAGE;
			state_q.reg_pg      <= `RST_REG_PAGE;
			state_q.mode_b_filt <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Outputs straight from the state flops.
	assign nv_prog_strobe   = state_q.nv_strobe;
	assign nv_prog_data     = state_q.nv_data;
	assign pready           = state_q.ready;
	assign prdata           = state_q.rdata;
	assign pslverr          = state_q.slverr;
	assign map_sel          = state_q.sel;
	assign config_latch     = state_q.cfg; // [R1]
	assign option_bits      = state_q.opt;
	assign ram_page         = state_q.ram_pg;
	assign reg_page         = state_q.reg_pg;
	assign special_mode     = state_q.special_mode_flag;
	assign security_enabled = state_q.sec_en;
	assign watchdog_disable = state_q.wdog_dis;

endmodule
`default_nettype wire

// ### design/sysinit_defs.svh
// Constants for the startup configuration and memory map block.
// Summary of operation
// [R1] Each reset sequence copies the nonvolatile configuration byte into working latches.
// [R2] Programming the nonvolatile byte changes nothing until the next reset sequence.
// [R3] Writes to the configuration location program the cell; reads return latches.
// [R4] Security-off reads 1 without the security option; else 0 enables security.
// [R5] Watchdog-off at 1 disables the watchdog, at 0 leaves it enabled.
// [R6] ROM-enable latch at 0 removes ROM; its range goes to the external bus.
// [R7] Single-chip mode always maps internal ROM, whatever the ROM-enable bit holds.
// [R8] EEPROM-enable latch at 0 removes EEPROM to external bus; at 1 maps it.
// [R9] Page-field variant places 2048-byte EEPROM at page x800 to xFFF.
// [R10] Bootstrap and test keep watchdog-off across reset; test register bit governs watchdog.
// [R11] Normal modes: mapping register takes one write, only in first 64 cycles.
// [R12] RAM position field gives RAM's top address digit; reset selects page 0.
// [R13] Register-block field gives the 64-byte block's top digit; reset selects page 1.
// [R14] Time-protected option bits accept a single write after reset, then read-only.
// [R15] Normal modes limit that write to 64 cycles; special modes write anytime.
// [R16] Special-mode flag set makes protected registers freely writable at any time.
// [R17] A relocation takes effect on the access following the write.
`ifndef SYSINIT_DEFS_SVH
`define SYSINIT_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_OPTION       16'h1039
`define IDX_MAP_POSITION 16'h103D
`define IDX_TEST_CTRL    16'h103E
`define IDX_CONFIG       16'h103F
`define IDX_STATUS       16'h1030

// Configuration byte field positions.
`define CFG_EE_PAGE_HI   7
`define CFG_EE_PAGE_LO   4
`define CFG_SEC_OFF      3
`define CFG_WDOG_OFF     2
`define CFG_ROM_EN       1
`define CFG_EE_EN        0

// Reset values.
`define RST_OPTION       8'h10
`define RST_RAM_PAGE     4'h0
`define RST_REG_PAGE     4'h1
`define RST_CONFIG       8'h00

// Once-only window after a reset sequence, in E-clock cycles.
`define WINDOW_CYCLES    7'd64

// Edges after reset release before the mode filter holds the pin levels.
`define SETTLE_CYCLES    3'd4

// Size of the register block and offset of the paged EEPROM within its page.
`define REG_BLOCK_BYTES  12'h040
`define EE_PAGE_OFFSET   12'h800

`endif

// ### design/sysinit_pkg.sv
// Types shared by the startup configuration and memory map block.
`default_nettype none
package sysinit_pkg;

	// Working latches of the configuration byte.
	typedef struct packed {
		logic [3:0] eeprom_page_select;
		logic       security_off;
		logic       watchdog_off;
		logic       rom_map_enable;
		logic       eeprom_map_enable;
	} config_s;

	// System options register layout, bit 2 unimplemented.
	typedef struct packed {
		logic       adc_power_up;
		logic       alt_clock_select;
		logic       irq_edge_only;
		logic       stop_wake_delay;
		logic       clock_monitor_enable;
		logic       unused_zero;
		logic [1:0] watchdog_rate;
	} option_s;

	// Registered memory-map selects for one CPU access.
	typedef struct packed {
		logic regs;
		logic ram;
		logic eeprom;
		logic rom;
		logic external;
	} map_sel_s;

	// Reset sequencer states.
	typedef enum logic [1:0] {
		ST_LOAD = 2'b01,
		ST_RUN  = 2'b10
	} seq_state_e;

endpackage
`default_nettype wire

// ### tb/sysinit_cfg_checker.sv
// Port assertions for the startup configuration and memory map block.
`default_nettype none
module sysinit_cfg_checker
	import sysinit_pkg::*;
(
	input wire logic                  ref_clk,
	input wire logic                  arst_n,
	input wire logic                  sys_reset_req,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [15:0]           paddr,
	input wire logic                  pready,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	input wire logic                  nv_prog_strobe,
	input wire logic                  cpu_req,
	input wire logic [15:0]           cpu_addr,
	input wire sysinit_pkg::map_sel_s map_sel,
	input wire sysinit_pkg::config_s  config_latch,
	input wire logic [3:0]            ram_page,
	input wire logic [3:0]            reg_page,
	input wire logic                  special_mode,
	input wire logic                  security_enabled,
	input wire logic                  watchdog_disable
);
	// Committed writes to the configuration and mapping locations.
	logic cfg_wr;
	logic map_wr;
	assign cfg_wr = psel && penable && pready && pwrite && paddr == 16'h40FC;
	assign map_wr = psel && penable && pready && pwrite && paddr == 16'h40F4;

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	// Derived outputs are only compared once a full cycle out of reset has passed.
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready did not follow the access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready stood longer than one cycle");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error response without ready or with data");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read data bits not zero");
	a_sec_follow: assert property ($past(arst_n)
		|-> security_enabled == !config_latch.security_off)
		else $error("security output disagrees with its latch");
	a_wdog_norm: assert property ($past(arst_n) && !special_mode
		|-> watchdog_disable == config_latch.watchdog_off)
		else $error("watchdog disable disagrees with its latch");
	a_prog_cause: assert property ($rose(nv_prog_strobe)
		|-> $past(cfg_wr, 1) || $past(cfg_wr, 2))
		else $error("programming pulse without a configuration write");
	a_prog_pulse: assert property (nv_prog_strobe |=> !nv_prog_strobe)
		else $error("programming pulse longer than one cycle");
	a_map_idle: assert property (!cpu_req |=> map_sel == 5'h00)
		else $error("select raised without an access");
	a_map_onehot: assert property (cpu_req |=> $onehot(map_sel))
		else $error("access select not one-hot");
	a_regs_win: assert property (cpu_req && cpu_addr[15:12] == reg_page
		&& cpu_addr[11:0] < 12'h040 |=> map_sel.regs)
		else $error("register block access not selected");
	a_page_hold: assert property ($changed({ram_page, reg_page}) |-> $past(map_wr)
		|| $past(sys_reset_req) || $past(sys_reset_req, 2))
		else $error("page position changed without a write");
endmodule

bind sysinit_cfg sysinit_cfg_checker u_sysinit_cfg_checker (.ref_clk, .arst_n, .sys_reset_req,
	.psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr, .nv_prog_strobe, .cpu_req,
	.cpu_addr, .map_sel, .config_latch, .ram_page, .reg_page, .special_mode,
	.security_enabled, .watchdog_disable);
`default_nettype wire

// ### tb/sysinit_cfg_tb_top.sv
// Self-checking testbench for the startup configuration and memory map block.
`default_nettype none
module sysinit_cfg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sysinit_pkg::*;

	// Inputs start idle; the configuration cell starts with watchdog off and EEPROM on.
	logic        ref_clk        = 1'b0;
	logic        arst_n         = 1'b0;
	logic        sys_reset_req  = 1'b0;
	logic        mode_b_pin     = 1'b1;
	logic        mode_a_pin     = 1'b0;
	logic [7:0]  nv_config_cell = 8'h05;
	logic        psel           = 1'b0;
	logic        penable        = 1'b0;
	logic        pwrite         = 1'b0;
	logic [15:0] paddr          = 16'h0000;
	logic [31:0] pwdata         = 32'h0000_0000;
	logic        cpu_req        = 1'b0;
	logic [15:0] cpu_addr       = 16'h0000;
	logic        nv_prog_strobe;
	logic [7:0]  nv_prog_data;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	map_sel_s    map_sel;
	config_s     config_latch;
	option_s     option_bits;
	logic [3:0]  ram_page;
	logic [3:0]  reg_page;
	logic        special_mode;
	logic        security_enabled;
	logic        watchdog_disable;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  prog_seen;
	int          prog_count = 0;
	int          fail_count = 0;
	int          compares   = 0;

	sysinit_cfg u_sysinit_cfg (
		.ref_clk, .arst_n, .sys_reset_req, .mode_b_pin, .mode_a_pin, .nv_config_cell,
		.nv_prog_strobe, .nv_prog_data, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .cpu_req, .cpu_addr, .map_sel, .config_latch, .option_bits,
		.ram_page, .reg_page, .special_mode, .security_enabled, .watchdog_disable
	);

	always #4 ref_clk = ~ref_clk;

	// Counts programming pulses so that a lost or doubled pulse shows up.
	always @(posedge ref_clk)
	begin
		if (nv_prog_strobe === 1'b1)
		begin
			prog_count <= prog_count + 1;
			prog_seen  <= nv_prog_data;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict;
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One APB transfer; an idle edge follows so the next setup never collides.
	task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
		if (n >= 20)
		begin
			fail_count++;
			print_verdict();
		end
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string w);
		apb(1'b0, a, 8'h00);
		check(w, rd, {24'h00_0000, e});
	endtask

	// The select is registered, so it is read at the edge after the request.
	task automatic cpu(input logic [15:0] a, input logic [4:0] e);
		cpu_req  <= 1'b1;
		cpu_addr <= a;
		@(posedge ref_clk);
		cpu_req <= 1'b0;
		@(posedge ref_clk);
		check("map_sel", map_sel, {27'h0, e});
	endtask

	task automatic hard_reset(input logic b, input logic a, input logic [7:0] nv);
		arst_n         <= 1'b0;
		mode_b_pin     <= b;
		mode_a_pin     <= a;
		nv_config_cell <= nv;
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		// The first reset sequence waits for the mode filter before it loads.
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic soft_reset;
		sys_reset_req <= 1'b1;
		@(posedge ref_clk);
		sys_reset_req <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic t_normal;
		hard_reset(1'b1, 1'b0, 8'h05);
		apb(1'b1, 16'h40F4, 8'h23);
		apb(1'b1, 16'h40E4, 8'hFF);
		apb(1'b1, 16'h40F4, 8'h45);
		apb(1'b1, 16'h40E4, 8'h00);
		rchk(16'h40F4, 8'h23, "map once");
		rchk(16'h40E4, 8'h33, "option once");
		check("option pins", option_bits, 8'h33);
		check("page pins", {ram_page, reg_page}, 8'h23);
		cpu(16'h2010, 5'h08);
		cpu(16'h3010, 5'h10);
		rchk(16'h40FC, 8'h05, "config");
		check("security", security_enabled, 1'b1);
		check("wdog", watchdog_disable, 1'b1);
		apb(1'b0, 16'h4000, 8'h00);
		check("slverr", err, 1'b1);
	endtask

	// Writes arriving after the startup window must leave the reset values.
	task automatic t_late;
		hard_reset(1'b1, 1'b0, 8'h05);
		rchk(16'h40F4, 8'h01, "map reset");
		rchk(16'h40E4, 8'h10, "option reset");
		repeat (70) @(posedge ref_clk);
		apb(1'b1, 16'h40F4, 8'h23);
		apb(1'b1, 16'h40E4, 8'h03);
		rchk(16'h40F4, 8'h01, "map late");
		rchk(16'h40E4, 8'h10, "option late");
	endtask

	task automatic t_config;
		int base;
		base = prog_count;
		apb(1'b1, 16'h40FC, 8'h0A);
		repeat (3) @(posedge ref_clk);
		check("prog count", prog_count - base, 1);
		check("prog data", prog_seen, 8'h0A);
		nv_config_cell <= 8'h0A;
		rchk(16'h40FC, 8'h05, "config held");
		soft_reset();
		rchk(16'h40FC, 8'h0A, "config reload");
		check("security", security_enabled, 1'b0);
		check("wdog", watchdog_disable, 1'b0);
	endtask

	task automatic t_decode;
		hard_reset(1'b1, 1'b0, 8'h05);
		cpu(16'hE000, 5'h02);
		cpu(16'hB700, 5'h04);
		cpu(16'h8000, 5'h01);
		hard_reset(1'b1, 1'b1, 8'h05);
		cpu(16'hE000, 5'h01);
		hard_reset(1'b1, 1'b1, 8'h04);
		cpu(16'hB700, 5'h01);
	endtask

	task automatic t_special;
		hard_reset(1'b0, 1'b0, 8'h05);
		check("special_mode_flag", special_mode, 1'b1);
		check("wdog latch", config_latch.watchdog_off, 1'b0);
		apb(1'b1, 16'h40F8, 8'h01);
		check("wdog test", watchdog_disable, 1'b1);
		repeat (70) @(posedge ref_clk);
		apb(1'b1, 16'h40F4, 8'h23);
		apb(1'b1, 16'h40F4, 8'h45);
		apb(1'b1, 16'h40E4, 8'h03);
		rchk(16'h40F4, 8'h45, "map special");
		rchk(16'h40E4, 8'h03, "option special");
		soft_reset();
		check("wdog kept", config_latch.watchdog_off, 1'b0);
	endtask

	initial
	begin
		t_normal();
		t_late();
		t_config();
		t_decode();
		t_special();
		print_verdict();
	end
endmodule
`default_nettype wire
